// file: rtl/nfh_pkg.sv
// Package for the NAND unique-ID and feature-access host controller.
// Assumes a 100 MHz system clock and a target run in timing mode 0.
package nfh_pkg;

  localparam int CLK_MHZ = 100;

  // Whole cycles covering a least time, never fewer than one.
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_WP_NS = 50;
  localparam int T_WH_NS = 30;
  // Read strobe low covers access time plus the two-stage data sampler.
  localparam int T_RP_NS = 70;
  localparam int T_REH_NS = 30;
  localparam int T_WB_NS = 100;
  localparam int T_ADL_NS = 200;
  localparam int T_CCS_NS = 500;
  localparam int N_WP = ns2cyc(T_WP_NS);
  localparam int N_WH = ns2cyc(T_WH_NS);
  localparam int N_RP = ns2cyc(T_RP_NS);
  localparam int N_REH = ns2cyc(T_REH_NS);
  localparam int N_WB = ns2cyc(T_WB_NS);
  localparam int N_ADL = ns2cyc(T_ADL_NS);
  localparam int N_CCS = ns2cyc(T_CCS_NS);

  localparam logic [7:0] CMD_UID = 8'hED;
  localparam logic [7:0] CMD_SETF = 8'hEF;
  localparam logic [7:0] CMD_GETF = 8'hEE;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RND_A = 8'h05;
  localparam logic [7:0] CMD_RND_B = 8'hE0;
  localparam logic [7:0] UID_ADDR = 8'h00;
  localparam int SR_RDY_BIT = 6;

  localparam logic [7:0] FA_TIMING = 8'h01;
  localparam logic [7:0] FA_DRIVE = 8'h80;
  localparam logic [7:0] FA_RB_PULL = 8'h81;
  localparam logic [7:0] FA_ARRAY_MODE = 8'h90;
  localparam logic [7:0] MASK_TIMING = 8'h07;
  localparam logic [7:0] MASK_DRIVE = 8'h03;
  localparam logic [7:0] MASK_RB_PULL = 8'h03;
  localparam logic [7:0] MASK_ARRAY = 8'h03;

  localparam int UID_COPIES = 16;
  localparam int UID_COPY_BYTES = 32;
  localparam int UID_HALF = 16;
  localparam logic [7:0] UID_XOR_OK = 8'hFF;

  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_WPARAM = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_RPARAM = 3'h3;
  localparam logic [2:0] REG_UID0 = 3'h4;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_POLL_BIT = 3;
  localparam int CTRL_FA_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_UID_OK_BIT = 2;
  localparam int ST_UID_BAD_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_RB_BIT = 5;
  localparam int ST_COPY_LSB = 8;

  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDAT, K_RDAT} nfh_kind_type;
  typedef enum logic [1:0] {OP_UID, OP_SETF, OP_GETF, OP_NONE} nfh_op_type;

  // Writable bits of a parameter byte; all others are sent as zero.
  function automatic logic [7:0] pmask(input logic [7:0] fa,
                                       input logic [1:0] idx);
    if (idx != 2'h0) return 8'h00;
    case (fa)
      FA_TIMING: return MASK_TIMING;
      FA_DRIVE: return MASK_DRIVE;
      FA_RB_PULL: return MASK_RB_PULL;
      FA_ARRAY_MODE: return MASK_ARRAY;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic fa_known(input logic [7:0] fa);
    return (fa == FA_TIMING) || (fa == FA_DRIVE) || (fa == FA_RB_PULL) ||
           (fa == FA_ARRAY_MODE);
  endfunction

endpackage

// file: rtl/nfh_cyc_if.sv
// Interface between the command sequencer and the pin cycle engine.
// Assumes both ends share one clock; req and done are one-cycle pulses.
`timescale 1ns/1ps
interface nfh_cyc_if;
  import nfh_pkg::*;
  logic req;
  nfh_kind_type kind;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport ctl (output req, output kind, output wdata,
               input done, input rdata);
  modport seq (input req, input kind, input wdata,
               output done, output rdata);
endinterface

// file: rtl/nfh_cycle.sv
// Pin cycle engine: one command, address, data-in or data-out bus cycle.
// Assumes a new req only after done; dq input comes from the pins.
`timescale 1ns/1ps
module nfh_cycle #(
  parameter int DQ_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  nfh_cyc_if.seq cyc,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic read_strobe_n,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n,
  input wire logic [DQ_W-1:0] dq_i
);
  import nfh_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} nfh_cst_type;
  nfh_cst_type st_q;
  logic [3:0] cnt_q;
  logic rd_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;

  wire low_end_w = cnt_q == (rd_q ? 4'(N_RP - 1) : 4'(N_WP - 1));
  wire high_end_w = cnt_q == (rd_q ? 4'(N_REH - 1) : 4'(N_WH - 1));
  wire is_rd_w = cyc.kind == K_RDAT;

  always_ff @(posedge clk) begin
    // Only the low byte is sampled; a wide part's upper lanes are ignored.
    dq_s1_q <= dq_i[7:0];
    dq_s2_q <= dq_s1_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= C_IDLE;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      dq_o <= '0;
      dq_oe_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= 8'h00;
    end else begin
      cyc.done <= 1'b0;
      cnt_q <= cnt_q + 4'h1;
      unique case (st_q)
        C_IDLE: begin
          if (cyc.req) begin
            st_q <= C_LOW;
            cnt_q <= 4'h0;
            rd_q <= is_rd_w;
            cle <= cyc.kind == K_CMD;
            ale <= cyc.kind == K_ADDR;
            we_n <= is_rd_w;
            read_strobe_n <= !is_rd_w;
            dq_o <= DQ_W'(cyc.wdata);
            dq_oe_n <= is_rd_w;
          end
        end
        C_LOW: begin
          if (low_end_w) begin
            // The device latches on this rising edge; data holds after it.
            st_q <= C_HIGH;
            cnt_q <= 4'h0;
            we_n <= 1'b1;
            read_strobe_n <= 1'b1;
            if (rd_q) begin
              cyc.rdata <= dq_s2_q;
            end
          end
        end
        C_HIGH: begin
          if (high_end_w) begin
            st_q <= C_IDLE;
            cle <= 1'b0;
            ale <= 1'b0;
            dq_oe_n <= 1'b1;
            cyc.done <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule // nfh_cycle

// file: rtl/nfh_ctrl.sv
// Host controller for the unique-ID read and the feature set/get commands.
// Assumes an Avalon-MM master on the clk domain and one NAND target.
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// R01: Device takes these commands only with all dies idle.
// R02: Code EDh puts the target into unique-ID read mode.
// R03: Unique-ID command is followed by one address 00h, then busy.
// R04: After status polling, command 00h comes before data output.
// R05: Device gives one unique-ID byte per read strobe toggle.
// R06: Sixteen 32-byte copies: 16 data bytes then their complement.
// R07: Host XORs halves; accepts only all FFh, else tries next copy.
// R08: Host may move output position with 05h-E0h pair.
// R09: Upper eight lines of a wide device carry nothing.
// R10: Set EFh and get EEh take a one-byte feature address.
// R11: Feature map: 01h timing, 80h drive, 81h pull-down, 90h array.
// R12: Address 90h P1: 00h normal, 01h one-time-programmable, protect bit.
// R13: Array mode returns to 00h at power cycle; P2-P4 zero.
// R14: Code EFh enters set-features mode until another command.
// R15: Host waits address-to-data delay before first parameter byte.
// R16: Device latches one parameter per rising write strobe.
// R17: After fourth parameter device is busy feature time; poll allowed.
// R18: Interface change at 01h makes busy the interface-change time.
// R19: Code EEh enters get-features mode until another command.
// R20: Get-features: busy feature time, then four bytes to read.
// R21: Host never issues 78h before or during get-features output.
// R22: Host writes zero to reserved bits; reads them as zero.
module nfh_ctrl #(
  parameter int DQ_W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic read_strobe_n,
  output logic [DQ_W-1:0] nand_dq_o,
  output logic nand_dq_oe_n,
  input wire logic [DQ_W-1:0] nand_dq_i,
  input wire logic ready_busy_n
);
  import nfh_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_FADDR, S_ADL, S_WDATA, S_WB, S_RBWAIT, S_POLLC,
    S_POLLR, S_RDMODE, S_RDATA, S_RELC, S_RELA, S_RELE, S_CCS
  } nfh_state_type;

  nfh_cyc_if cyc ();

  nfh_state_type state_q;
  nfh_op_type op_q;
  logic poll_q;
  logic [7:0] fa_q;
  logic [31:0] wparam_q;
  logic [31:0] rparam_q;
  logic [7:0] uid_q [UID_HALF];
  logic [4:0] byte_q;
  logic [3:0] copy_q;
  logic mism_q;
  logic issued_q;
  logic [15:0] timer_q;
  logic done_q;
  logic uid_ok_q;
  logic uid_bad_q;
  logic refused_q;
  logic rb_s1_q;
  logic rb_s2_q;
  logic req_q;
  nfh_kind_type kind_q;
  logic [7:0] wdata_q;
  logic [7:0] last_cmd_q;
  logic [15:0] adl_cnt_q;

  assign cyc.req = req_q;
  assign cyc.kind = kind_q;
  assign cyc.wdata = wdata_q;

  nfh_cycle #(.DQ_W(DQ_W)) u_cycle (
    .clk(clk),
    .sys_rst(sys_rst),
    .cyc(cyc),
    .cle(nand_cle),
    .ale(nand_ale),
    .we_n(nand_we_n),
    .read_strobe_n(read_strobe_n),
    .dq_o(nand_dq_o),
    .dq_oe_n(nand_dq_oe_n),
    .dq_i(nand_dq_i)
  );

  // Register bus decode and command acceptance.
  wire bus_take_w = (avs_read || avs_write) && avs_waitrequest;
  // A write lands only at the edge that completes the transfer, when the
  // master samples waitrequest low, never at the edge that takes it.
  wire wr_w = avs_write && !avs_waitrequest;
  wire [31:0] be_mask_w = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire start_w = wr_w && avs_address == REG_CTRL && avs_byteenable[0] &&
                 avs_writedata[CTRL_START_BIT];
  wire nfh_op_type req_op_w = nfh_op_type'(avs_writedata[CTRL_OP_LSB +: 2]);
  wire [7:0] req_fa_w = avs_writedata[CTRL_FA_LSB +: 8];
  wire op_ok_w = req_op_w == OP_UID ||
                 ((req_op_w == OP_SETF || req_op_w == OP_GETF) &&
                  fa_known(req_fa_w));
  wire accept_w = start_w && state_q == S_IDLE && rb_s2_q && op_ok_w;

  wire [15:0] st_word_w = {4'h0, copy_q, 2'h0, rb_s2_q, refused_q,
                           uid_bad_q, uid_ok_q, done_q, state_q != S_IDLE};
  wire [31:0] ctrl_word_w = {16'h0, fa_q, 4'h0, poll_q, op_q, 1'b0};
  wire [2:0] uid_base_w = avs_address - REG_UID0;
  wire [31:0] uid_word_w = {uid_q[{uid_base_w[1:0], 2'h3}],
                            uid_q[{uid_base_w[1:0], 2'h2}],
                            uid_q[{uid_base_w[1:0], 2'h1}],
                            uid_q[{uid_base_w[1:0], 2'h0}]};
  wire [31:0] rd_mux_w =
    (avs_address == REG_CTRL) ? ctrl_word_w :
    (avs_address == REG_WPARAM) ? wparam_q :
    (avs_address == REG_STATUS) ? {16'h0, st_word_w} :
    (avs_address == REG_RPARAM) ? rparam_q : uid_word_w;

  // Bytes driven on the pins in each issuing state.
  wire [8:0] col_w = {copy_q, 5'h00};
  wire [7:0] op_cmd_w = (op_q == OP_UID) ? CMD_UID :
                        (op_q == OP_SETF) ? CMD_SETF : CMD_GETF;
  wire [7:0] wpar_w = wparam_q[{byte_q[1:0], 3'h0} +: 8] &
                      pmask(fa_q, byte_q[1:0]);
  wire issuing_w = state_q inside {S_CMD, S_FADDR, S_WDATA, S_POLLC,
                                   S_POLLR, S_RDMODE, S_RDATA, S_RELC,
                                   S_RELA, S_RELE};
  wire fire_w = issuing_w && !issued_q;
  wire nfh_kind_type kind_w =
    (state_q inside {S_FADDR, S_RELA}) ? K_ADDR :
    (state_q == S_WDATA) ? K_WDAT :
    (state_q inside {S_POLLR, S_RDATA}) ? K_RDAT : K_CMD;
  wire [7:0] byte_out_w =
    (state_q == S_CMD) ? op_cmd_w :
    (state_q == S_FADDR) ? ((op_q == OP_UID) ? UID_ADDR : fa_q) :
    (state_q == S_WDATA) ? wpar_w :
    (state_q == S_POLLC) ? CMD_STATUS :
    (state_q == S_RELC) ? CMD_RND_A :
    (state_q == S_RELA) ? (byte_q[0] ? {7'h00, col_w[8]} : col_w[7:0]) :
    (state_q == S_RELE) ? CMD_RND_B : CMD_READ_MODE;

  // Unique-ID copy check on the fly against the stored first half.
  wire dn_w = cyc.done;
  wire [7:0] xor_w = uid_q[byte_q[3:0]] ^ cyc.rdata;
  wire chk_w = dn_w && state_q == S_RDATA && op_q == OP_UID &&
               byte_q == 5'(UID_COPY_BYTES - 1);
  wire match_w = !mism_q && xor_w == UID_XOR_OK;
  wire rdy_bit_w = cyc.rdata[SR_RDY_BIT];
  wire timer_zero_w = timer_q == 16'h0000;

  always_ff @(posedge clk) begin
    rb_s1_q <= ready_busy_n;
    rb_s2_q <= rb_s1_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      op_q <= OP_NONE;
      poll_q <= 1'b0;
      fa_q <= 8'h00;
      wparam_q <= 32'h0000_0000;
      refused_q <= 1'b0;
    end else begin
      avs_waitrequest <= !bus_take_w;
      if (bus_take_w) begin
        avs_readdata <= avs_read ? rd_mux_w : 32'h0000_0000;
      end
      if (wr_w && avs_address == REG_WPARAM) begin
        wparam_q <= (wparam_q & ~be_mask_w) | (avs_writedata & be_mask_w);
      end
      if (start_w) begin
        refused_q <= !accept_w; // [R01]
      end
      if (accept_w) begin
        op_q <= req_op_w;
        poll_q <= avs_writedata[CTRL_POLL_BIT];
        fa_q <= req_fa_w;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      issued_q <= 1'b0;
      req_q <= 1'b0;
      kind_q <= K_CMD;
      wdata_q <= 8'h00;
      byte_q <= 5'h00;
      copy_q <= 4'h0;
      mism_q <= 1'b0;
      timer_q <= 16'h0000;
      done_q <= 1'b0;
      uid_ok_q <= 1'b0;
      uid_bad_q <= 1'b0;
      rparam_q <= 32'h0000_0000;
      nand_ce_n <= 1'b1;
    end else begin
      req_q <= fire_w;
      if (fire_w) begin
        issued_q <= 1'b1;
        kind_q <= kind_w;
        wdata_q <= byte_out_w;
      end
      if (dn_w) begin
        issued_q <= 1'b0;
      end
      if (!timer_zero_w) begin
        timer_q <= timer_q - 16'h0001;
      end
      nand_ce_n <= state_q == S_IDLE && !accept_w;
      unique case (state_q)
        S_IDLE: if (accept_w) begin
          state_q <= S_CMD;
          done_q <= 1'b0;
          uid_ok_q <= 1'b0;
          uid_bad_q <= 1'b0;
          copy_q <= 4'h0;
          byte_q <= 5'h00;
          mism_q <= 1'b0;
        end
        S_CMD: if (dn_w) state_q <= S_FADDR;
        S_FADDR: if (dn_w) begin
          state_q <= (op_q == OP_SETF) ? S_ADL : S_WB; // [R03]
          timer_q <= (op_q == OP_SETF) ? 16'(N_ADL) : 16'(N_WB);
        end
        S_ADL: if (timer_zero_w) state_q <= S_WDATA; // [R15]
        S_WDATA: if (dn_w) begin
          byte_q <= byte_q + 5'h01;
          if (byte_q[1:0] == 2'h3) begin
            state_q <= S_WB;
            timer_q <= 16'(N_WB);
            byte_q <= 5'h00;
          end
        end
        // The busy line may lag the last cycle, so it is not read early.
        S_WB: if (timer_zero_w) state_q <= poll_q ? S_POLLC : S_RBWAIT;
        S_RBWAIT: if (rb_s2_q) begin
          state_q <= (op_q == OP_SETF) ? S_IDLE : S_RDATA;
          done_q <= op_q == OP_SETF;
        end
        S_POLLC: if (dn_w) state_q <= S_POLLR;
        S_POLLR: if (dn_w && rdy_bit_w) begin
          state_q <= (op_q == OP_SETF) ? S_IDLE : S_RDMODE; // [R04]
          done_q <= op_q == OP_SETF;
        end
        S_RDMODE: if (dn_w) state_q <= S_RDATA;
        S_RDATA: if (dn_w) begin
          byte_q <= byte_q + 5'h01;
          if (op_q == OP_GETF) begin
            // Reserved bits read back are cleared before software sees them.
            rparam_q[{byte_q[1:0], 3'h0} +: 8] <=
              cyc.rdata & pmask(fa_q, byte_q[1:0]); // [R22]
            if (byte_q[1:0] == 2'h3) begin
              state_q <= S_IDLE;
              done_q <= 1'b1;
            end
          end else if (byte_q < 5'(UID_HALF)) begin
            uid_q[byte_q[3:0]] <= cyc.rdata;
          end else begin
            mism_q <= mism_q || xor_w != UID_XOR_OK; // [R07]
            if (chk_w) begin
              byte_q <= 5'h00;
              mism_q <= 1'b0;
              if (match_w) begin
                state_q <= S_IDLE;
                done_q <= 1'b1;
                uid_ok_q <= 1'b1;
              end else if (copy_q == 4'(UID_COPIES - 1)) begin
                state_q <= S_IDLE;
                done_q <= 1'b1;
                uid_bad_q <= 1'b1;
              end else begin
                copy_q <= copy_q + 4'h1;
                state_q <= S_RELC; // [R08]
              end
            end
          end
        end
        S_RELC: if (dn_w) state_q <= S_RELA;
        S_RELA: if (dn_w) begin
          byte_q <= byte_q + 5'h01;
          if (byte_q[0]) begin
            state_q <= S_RELE;
            byte_q <= 5'h00;
          end
        end
        S_RELE: if (dn_w) begin
          state_q <= S_CCS;
          timer_q <= 16'(N_CCS);
        end
        S_CCS: if (timer_zero_w) state_q <= S_RDATA;
      endcase
    end
  end

  // Helper history for the checks below.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_cmd_q <= 8'h00;
      adl_cnt_q <= 16'h0000;
    end else begin
      if (req_q && kind_q == K_CMD) begin
        last_cmd_q <= wdata_q;
      end
      if (dn_w && kind_q == K_ADDR) begin
        adl_cnt_q <= 16'h0000;
      end else if (adl_cnt_q != 16'hFFFF) begin
        adl_cnt_q <= adl_cnt_q + 16'h0001;
      end
    end
  end

  sequence s_uid_addr;
    req_q && kind_q == K_ADDR && last_cmd_q == CMD_UID;
  endsequence

  property p_r03;
    @(posedge clk) disable iff (sys_rst)
      s_uid_addr |-> wdata_q == UID_ADDR ##1 !req_q [*4];
  endproperty
  a_r03: assert property (p_r03) else $error("bad unique-ID address"); // [R03]

  property p_r04;
    @(posedge clk) disable iff (sys_rst)
      (req_q && state_q == S_RDATA) |-> last_cmd_q != CMD_STATUS;
  endproperty
  a_r04: assert property (p_r04) else $error("data read after status"); // [R04]

  property p_r07;
    @(posedge clk) disable iff (sys_rst)
      chk_w |=> (uid_ok_q == $past(match_w));
  endproperty
  a_r07: assert property (p_r07) else $error("copy check wrong"); // [R07]

  sequence s_reloc_end;
    req_q && kind_q == K_CMD && wdata_q == CMD_RND_B;
  endsequence

  property p_r08;
    @(posedge clk) disable iff (sys_rst)
      s_reloc_end |-> last_cmd_q == CMD_RND_A && col_w[4:0] == 5'h00;
  endproperty
  a_r08: assert property (p_r08) else $error("relocate pair broken"); // [R08]

  property p_r15;
    @(posedge clk) disable iff (sys_rst)
      (req_q && kind_q == K_WDAT && byte_q == 5'h00) |->
        adl_cnt_q >= 16'(N_ADL);
  endproperty
  a_r15: assert property (p_r15) else $error("parameter too early"); // [R15]

  property p_r21;
    @(posedge clk) disable iff (sys_rst)
      (req_q && kind_q == K_CMD) |-> wdata_q != CMD_STATUS_ENH;
  endproperty
  a_r21: assert property (p_r21) else $error("enhanced status sent"); // [R21]

  property p_r22;
    @(posedge clk) disable iff (sys_rst)
      (req_q && kind_q == K_WDAT) |->
        (wdata_q & ~pmask(fa_q, byte_q[1:0])) == 8'h00;
  endproperty
  a_r22: assert property (p_r22) else $error("reserved bit written"); // [R22]

endmodule // nfh_ctrl

// file: testbench/nfh_nand_model.sv
// Behavioural NAND target: unique-ID read and feature set/get only.
// Assumes host strobes move on clk edges; busy time is counted in clk.
`timescale 1ns/1ps
module nfh_nand_model (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic [7:0] dq,
  input wire logic [15:0] bad_copy,
  input wire logic hold_busy,
  input wire logic [11:0] busy_cyc,
  output logic [7:0] dq_i,
  output logic rb_n,
  output int n_cmds,
  output int n_viol
);
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic stat = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [1:0] acnt = 2'h0;
  logic [1:0] pidx = 2'h0;
  logic [7:0] fa = 8'h00;
  logic [7:0] lo = 8'h00;
  logic [7:0] hi = 8'h00;
  logic [8:0] ptr = 9'h000;
  int busy = 0;
  time t_addr = 0;
  logic [7:0] fmem [256][4] = '{default: 8'h00};
  wire rdy = (busy == 0) && !hold_busy;
  wire we_rise = !ce_n && we_n && !we_q;
  assign rb_n = rdy;
  initial dq_i = 8'hA5;
  initial n_cmds = 0;
  initial n_viol = 0;

  // A bad copy leaves its last complement byte uncomplemented.
  function automatic logic [7:0] uid(input logic [8:0] p);
    logic [7:0] d;
    d = 8'h3C ^ {p[8:5], p[3:0]};
    if (!p[4]) return d;
    return (bad_copy[p[8:5]] && p[3:0] == 4'hF) ? d : ~d;
  endfunction

  always @(posedge clk) begin
    we_q <= we_n;
    re_q <= re_n;
    if (busy > 0) busy <= busy - 1;
    if (we_rise && cle && (rdy || dq == 8'h70)) begin
      n_cmds <= n_cmds + 1;
      stat <= (dq == 8'h70);
      if (dq == 8'h78 && mode == 2'h2) n_viol <= n_viol + 1;
      if (dq == 8'hED || dq == 8'hEF || dq == 8'hEE) begin
        mode <= dq[1:0];
        acnt <= 2'h1;
        pidx <= 2'h0;
      end
      if (dq == 8'h05) acnt <= 2'h3;
      if (dq == 8'hE0) ptr <= {hi[0], lo};
    end else if (we_rise && ale) begin
      t_addr <= $time;
      acnt <= (acnt == 2'h3) ? 2'h2 : 2'h0;
      if (acnt == 2'h3) lo <= dq;
      if (acnt == 2'h2) hi <= dq;
      if (acnt == 2'h1) begin
        fa <= dq;
        ptr <= 9'h000;
        if (mode != 2'h3) busy <= busy_cyc;
        if (mode == 2'h1 && dq != 8'h00) n_viol <= n_viol + 1;
      end
    end else if (we_rise && mode == 2'h3) begin
      fmem[fa][pidx] <= dq;
      pidx <= pidx + 2'h1;
      if (pidx == 2'h3) busy <= busy_cyc;
      if (($time - t_addr < 200) || ((dq & ((pidx != 2'h0) ? 8'hFF :
          (fa == 8'h01) ? 8'hF8 : 8'hFC)) != 8'h00))
        n_viol <= n_viol + 1;
    end
    if (!ce_n && !re_n && re_q) begin
      dq_i <= stat ? {1'b1, rdy, rdy, 5'h00} :
              (mode == 2'h1) ? uid(ptr) : fmem[fa][ptr[1:0]];
    end
    // Released data lines show the inverse, never the last byte.
    if (re_n && !re_q) begin
      dq_i <= ~dq_i;
      if (!stat) ptr <= ptr + 9'h001;
    end
  end
endmodule // nfh_nand_model

// file: testbench/nfh_ctrl_bench.sv
// Self-checking bench for the unique-ID and feature host controller.
// Assumes the behavioural target model on the NAND pins.
`timescale 1ns/1ps
module nfh_ctrl_bench;
  import nfh_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, st, q;
  logic avs_waitrequest, ce_n, cle, ale, we_n, re_n, oe_n, rb_n;
  logic hold_busy = 1'b0;
  logic [7:0] dq_o, dq_i;
  logic [15:0] bad_copy = 16'h0001;
  logic [11:0] busy_cyc = 12'h010;
  logic [7:0] fas [4] = '{FA_TIMING, FA_DRIVE, FA_RB_PULL, FA_ARRAY_MODE};
  logic [7:0] fv [4] = '{8'h05, 8'h01, 8'h02, 8'h01};
  logic [15:0] bads [3] = '{16'h0001, 16'h0007, 16'hFFFF};
  int n_cmds, n_viol, c0;
  int n_errors = 0;
  int total_checks = 0;

  initial forever #5 clk = ~clk;

  nfh_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .read_strobe_n(re_n), .nand_dq_o(dq_o), .nand_dq_oe_n(oe_n),
    .nand_dq_i(dq_i), .ready_busy_n(rb_n));

  nfh_nand_model far_u (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale),
    .we_n(we_n), .re_n(re_n), .dq(dq_o), .bad_copy(bad_copy),
    .hold_busy(hold_busy), .busy_cyc(busy_cyc), .dq_i(dq_i),
    .rb_n(rb_n), .n_cmds(n_cmds), .n_viol(n_viol));

  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // Starts one operation and polls status until it ends or is refused.
  task automatic run(input logic [1:0] op, input logic [7:0] fa,
                     input logic poll, output logic [31:0] s);
    logic [31:0] r;
    int n;
    bus(1'b1, REG_CTRL, {16'h0, fa, 4'h0, poll, op, 1'b1}, r);
    n = 0;
    do begin
      bus(1'b0, REG_STATUS, 32'h0, s);
      n++;
    end while (s[ST_DONE_BIT] !== 1'b1 && s[ST_REFUSED_BIT] !== 1'b1 &&
               n < 5000);
  endtask

  function automatic logic [31:0] uid_word(input logic [3:0] c,
                                           input logic [1:0] k);
    for (int j = 0; j < 4; j++) uid_word[8*j +: 8] = 8'h3C ^ {c, k, 2'(j)};
  endfunction

  task automatic conclude;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    check({26'h0, ce_n, cle, ale, we_n, re_n, oe_n}, 32'h27,
          "pins idle");
    bus(1'b0, REG_STATUS, 32'h0, st);
    check(st & 32'h3F, 32'h20, "status after reset");
    run(2'h2, FA_ARRAY_MODE, 1'b0, st);
    bus(1'b0, REG_RPARAM, 32'h0, q);
    check(q, 32'h0, "array mode at power-up");
    for (int k = 0; k < 4; k++) begin
      busy_cyc <= (k == 3) ? 12'h3E8 : 12'h010;
      bus(1'b1, REG_WPARAM, {24'h776655, 8'hF8 | fv[k]}, q);
      run(2'h1, fas[k], k[0], st);
      run(2'h2, fas[k], k[0], st);
      bus(1'b0, REG_RPARAM, 32'h0, q);
      check(q, {24'h0, fv[k]}, "readback");
    end
    for (int t = 0; t < 3; t++) begin
      bad_copy <= bads[t];
      run(2'h0, 8'h00, t[0], st);
      check({30'h0, st[ST_UID_BAD_BIT:ST_UID_OK_BIT]}, (t == 2) ? 32'h2 :
            32'h1, "uid verdict");
      if (t < 2) begin
        check({28'h0, st[ST_COPY_LSB +: 4]}, 1 + 2 * t, "copy");
      end
      for (int k = 0; k < 4 && t < 2; k++) begin
        bus(1'b0, REG_UID0 + 3'(k), 32'h0, q);
        check(q, uid_word(4'(1 + 2 * t), 2'(k)), "uid bytes");
      end
    end
    run(2'h2, FA_TIMING, 1'b1, st);
    bus(1'b0, REG_RPARAM, 32'h0, q);
    check(q, 32'h5, "get after unique id");
    c0 = n_cmds;
    run(2'h2, 8'h02, 1'b0, st);
    check({31'h0, st[ST_REFUSED_BIT]}, 32'h1, "reserved address");
    run(2'h3, FA_TIMING, 1'b0, st);
    check({31'h0, st[ST_REFUSED_BIT]}, 32'h1, "bad op");
    hold_busy <= 1'b1;
    repeat (4) @(posedge clk);
    run(2'h0, 8'h00, 1'b0, st);
    check({31'h0, st[ST_REFUSED_BIT]}, 32'h1, "start while busy");
    check(32'(n_cmds - c0), 32'h0, "no cycles when refused");
    check(32'(n_viol), 32'h0, "host protocol");
    conclude();
  end

  initial begin
    #900000;
    n_errors++;
    conclude();
  end
endmodule // nfh_ctrl_bench
